/* verilog/tie_core.sv */
// Overview of operation
// - master port-c read fills acc 7..0
// - slave read: ready, irq pin, pc 7..4
// - sign mode copies bit 7 upward
// - listed transfers, except index to acc, force status flag high
// - reduced pins read pc 7..4 high
// - timer read loads acc, selects pin
// - only timer read selects pin clock
// - index to acc with extension
// - index to port a, master drives
// - slave port-a write pulls irq low
// - slave port a floats until enable
// - host enable read releases irq high
// - timer load copies index value
// - underflow past zero raises timer event
// - swap b and index at once
// - compare index ge constant to flag
// - pitch zero selects noise excitation
// - fraction bits for first eight params
// - interpolate parameters toward new values
// - prescaler divides by value plus one
// - frame event swaps present/new banks
`timescale 1ns/10ps
module tie_core (
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // port a, port c, irq/timer pin
  input  wire logic [7:0]  pa_in,
  output logic [7:0]       pa_out,
  output logic [7:0]       pa_oe_n,
  input  wire logic [7:0]  pc_in,
  input  wire logic        irt_in,
  output logic             irt_out,
  output logic             irt_oe_n,
  // timer and synthesizer
  output logic             timer_irq,
  output logic [7:0]       excite,
  output logic             voiced
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [9:0]              acc;
    logic [7:0]              x;
    logic [7:0]              b;
    logic                    sf;
    logic [7:0]              tmr;
    logic [7:0]              presc;
    logic [7:0]              pcnt;
    logic                    src_ext;
    logic                    irt_prev;
    logic                    tevt;
    logic                    tirq;
    logic [7:0]              pa;
    logic [7:0]              pa_oe_n;
    logic                    irt_out;
    logic                    irt_oe_n;
    logic                    pend;
    logic [5:0]              ctrl;
    logic                    wr;
    logic [7:0]              wa;
    logic [31:0]             rdata;
    logic                    rdy;
    logic                    resp;
    logic                    bank;
    logic [1:0][11:0][11:0]  pv;
    logic [11:0][11:0]       cur;
    logic [11:0]             scnt;
    logic [7:0]              pch;
    logic [14:0]             lfsr;
    logic [7:0]              exc;
    logic                    voiced;
  } tie_state_t;

  tie_state_t s;
  tie_state_t next_s;

  // widen a byte into the accumulator per arithmetic mode
  function automatic logic [9:0] tie_ext(input logic [7:0] v,
                                         input logic       sgn);
    tie_ext = {sgn ? {2{v[7]}} : 2'b00, v};
  endfunction

  // ----------------------------------------------------------------
  // decode of the executing instruction
  // ----------------------------------------------------------------
  logic       ex;
  logic [7:0] op;
  logic [7:0] imm;
  logic       slave;
  logic       sgn;
  logic [7:0] pc_eff;
  logic       en_low;
  logic       src_tick;
  logic       ptick;
  logic       stick;
  logic       under;
  logic [3:0] pidx;

  assign ex     = s.wr && (s.wa == tie_pkg::A_INSTR);
  assign op     = hwdata[7:0];
  assign imm    = hwdata[15:8];
  assign slave  = s.ctrl[tie_pkg::C_SLAVE];
  assign sgn    = s.ctrl[tie_pkg::C_SIGN];
  // upper pins are absent on reduced parts and float high
  assign pc_eff = s.ctrl[tie_pkg::C_REDUCE] ?
                  {4'hf, pc_in[3:0]} : pc_in;
  // host enables sit on pc1/pc2 in slave mode
  assign en_low = slave && (!pc_in[1] || !pc_in[2]);
  // pin clock counts rising edges of the irq/timer input
  assign src_tick = s.src_ext ? (irt_in && !s.irt_prev) : 1'b1;
  assign ptick  = src_tick && (s.pcnt == s.presc);
  assign under  = ptick && (s.tmr == 8'h00) && !(ex && op == tie_pkg::OP_X_TO_TMR);
  assign stick  = (s.scnt == tie_pkg::SAMPLE_LAST);
  assign pidx   = 4'((s.wa - tie_pkg::A_PARAM) >> 2);

  // ----------------------------------------------------------------
  // read mux, sampled in the address phase
  // ----------------------------------------------------------------
  logic [31:0] rv;
  logic [7:0]  ra;
  logic [3:0]  ridx;

  assign ra   = haddr[7:0];
  assign ridx = 4'((ra - tie_pkg::A_PARAM) >> 2);

  always_comb begin
    rv = 32'h0000_0000;
    if (ra >= tie_pkg::A_PARAM && ra <= tie_pkg::A_PEND &&
        ra[1:0] == 2'b00) begin
      rv = {20'h00000, s.cur[ridx]};
    end else begin
      unique case (ra)
        tie_pkg::A_CTRL:  rv = {26'h0, s.ctrl};
        tie_pkg::A_ACC:   rv = {22'h0, s.acc};
        tie_pkg::A_X:     rv = {24'h0, s.x};
        tie_pkg::A_B:     rv = {24'h0, s.b};
        tie_pkg::A_STAT:  rv = {27'h0, s.pend, s.bank, s.tevt,
                                s.src_ext, s.sf};
        tie_pkg::A_TMR:   rv = {24'h0, s.tmr};
        tie_pkg::A_PRESC: rv = {24'h0, s.presc};
        tie_pkg::A_PORTA: rv = {16'h0, pa_in, s.pa};
        tie_pkg::A_EXC:   rv = {23'h0, s.voiced, s.exc};
        default:          rv = 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  logic signed [12:0] diff;

  always_comb begin
    next_s = s;
    diff = 13'sh0000;
    next_s.tirq = 1'b0;
    next_s.irt_prev = irt_in;
    next_s.irt_oe_n = !s.ctrl[tie_pkg::C_IRTOUT];

    // bus address phase; zero wait states, answer always okay
    next_s.wr = 1'b0;
    if (hsel && hready && htrans[1]) begin
      next_s.wr = hwrite;
      next_s.wa = ra;
      if (!hwrite) begin
        next_s.rdata = rv;
      end
    end

    // prescaler and timer
    if (src_tick) begin
      next_s.pcnt = ptick ? 8'h00 : 8'(s.pcnt + 8'h01);
    end
    if (ptick) begin
      next_s.tmr = 8'(s.tmr - 8'h01);
    end
    if (under) begin
      next_s.tirq = 1'b1;
      if (s.ctrl[tie_pkg::C_SYNTH]) begin
        next_s.bank = !s.bank;
        next_s.cur = s.pv[!s.bank];
      end
    end

    // host read in slave mode drives port a, releases irq
    if (slave) begin
      next_s.pa_oe_n = en_low ? 8'h00 : tie_pkg::PA_HIZ;
      if (en_low) begin
        next_s.pend = 1'b0;
        next_s.irt_out = 1'b1;
      end
    end

    // register writes
    if (s.wr) begin
      if (s.wa >= tie_pkg::A_PARAM && s.wa <= tie_pkg::A_PEND) begin
        // low nibble is the fraction, kept only where supported
        next_s.pv[!s.bank][pidx] = (pidx < 4'(tie_pkg::N_FRAC)) ?
          hwdata[11:0] : {hwdata[11:4], 4'h0};
      end
      unique case (s.wa)
        tie_pkg::A_CTRL:  next_s.ctrl = hwdata[5:0];
        tie_pkg::A_ACC:   next_s.acc = hwdata[9:0];
        tie_pkg::A_X:     next_s.x = hwdata[7:0];
        tie_pkg::A_B:     next_s.b = hwdata[7:0];
        tie_pkg::A_PRESC: next_s.presc = hwdata[7:0];
        tie_pkg::A_STAT: begin
          if (hwdata[tie_pkg::S_SRC]) begin
            next_s.src_ext = 1'b0;
          end
          if (hwdata[tie_pkg::S_TEVT]) begin
            next_s.tevt = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
    // event set after the clear, so a coincident event survives
    if (under) begin
      next_s.tevt = 1'b1;
    end

    // instruction execution
    if (ex) begin
      unique case (op)
        tie_pkg::OP_PC_TO_ACC: begin
          if (slave) begin
            next_s.acc = tie_ext({pc_eff[7:4], 2'b00, irt_in, pc_in[0]},
                                 sgn);
          end else begin
            next_s.acc = tie_ext(pc_eff, sgn);
          end
          next_s.sf = 1'b1;
        end
        tie_pkg::OP_TMR_TO_ACC: begin
          next_s.acc = tie_ext(s.tmr, sgn);
          next_s.src_ext = 1'b1;
          next_s.sf = 1'b1;
        end
        tie_pkg::OP_X_TO_ACC: begin
          next_s.acc = tie_ext(s.x, sgn);
        end
        tie_pkg::OP_X_TO_PA: begin
          next_s.pa = s.x;
          if (slave) begin
            next_s.pend = 1'b1;
            if (s.ctrl[tie_pkg::C_IRTOUT]) begin
              next_s.irt_out = 1'b0;
            end
          end else begin
            next_s.pa_oe_n = 8'h00;
          end
          next_s.sf = 1'b1;
        end
        tie_pkg::OP_X_TO_TMR: begin
          next_s.tmr = s.x;
          next_s.sf = 1'b1;
        end
        tie_pkg::OP_SWAP_BX: begin
          next_s.b = s.x;
          next_s.x = s.b;
          next_s.sf = 1'b1;
        end
        tie_pkg::OP_X_GE_CONST: begin
          next_s.sf = (s.x >= imm);
        end
        default: begin
        end
      endcase
    end

    // sample clock and synthesizer
    next_s.scnt = stick ? 12'h000 : 12'(s.scnt + 12'h001);
    if (!s.ctrl[tie_pkg::C_INTERP]) begin
      next_s.cur = s.pv[s.bank];
    end
    if (stick && s.ctrl[tie_pkg::C_SYNTH]) begin
      // coarse steps toward the new frame, a fraction each sample
      if (s.ctrl[tie_pkg::C_INTERP] && !under) begin
        for (int i = 0; i < tie_pkg::N_PARAM; i++) begin
          diff = 13'($signed({1'b0, s.pv[!s.bank][i]}) -
                     $signed({1'b0, s.cur[i]}));
          if (diff != 13'sh0000) begin
            next_s.cur[i] = (diff >>> tie_pkg::INTERP_SHIFT == 0) ?
              s.pv[!s.bank][i] :
              12'(s.cur[i] + 12'(diff >>> tie_pkg::INTERP_SHIFT));
          end
        end
      end
      if (s.cur[0][11:4] == 8'h00) begin
        next_s.lfsr = {s.lfsr[13:0], s.lfsr[14] ^ s.lfsr[13]};
        next_s.exc = s.lfsr[0] ? tie_pkg::EXC_NOISE_HI :
                                 tie_pkg::EXC_NOISE_LO;
        next_s.voiced = 1'b0;
      end else begin
        next_s.voiced = 1'b1;
        if (s.pch == 8'h00) begin
          next_s.pch = 8'(s.cur[0][11:4] - 8'h01);
          next_s.exc = tie_pkg::EXC_PULSE;
        end else begin
          next_s.pch = 8'(s.pch - 8'h01);
          next_s.exc = 8'h00;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '0;
      s.rdy <= 1'b1;
      s.pa_oe_n <= tie_pkg::PA_HIZ;
      s.irt_out <= 1'b1;
      s.irt_oe_n <= 1'b1;
      s.lfsr <= tie_pkg::LFSR_SEED;
    end else begin
      s <= next_s;
    end
  end

  // outputs straight from flops
  assign hreadyout = s.rdy;
  assign hresp     = s.resp;
  assign hrdata    = s.rdata;
  assign pa_out    = s.pa;
  assign pa_oe_n   = s.pa_oe_n;
  assign irt_out   = s.irt_out;
  assign irt_oe_n  = s.irt_oe_n;
  assign timer_irq = s.tirq;
  assign excite    = s.exc;
  assign voiced    = s.voiced;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_flag_forced: assert property (
    ex && (op == tie_pkg::OP_SWAP_BX || op == tie_pkg::OP_X_TO_TMR)
    |=> s.sf) else $error("status flag not forced high");

  a_pin_clock: assert property (
    ex && op == tie_pkg::OP_TMR_TO_ACC
    |=> s.src_ext && s.acc[7:0] == $past(s.tmr))
    else $error("timer read did not act");

  a_pin_only: assert property (
    $rose(s.src_ext) |-> $past(ex && op == tie_pkg::OP_TMR_TO_ACC))
    else $error("pin clock chosen without timer read");

  a_compare_ge: assert property (
    ex && op == tie_pkg::OP_X_GE_CONST
    |=> s.sf == ($past(s.x) >= $past(imm)))
    else $error("compare flag wrong");

  a_swap_bx: assert property (
    ex && op == tie_pkg::OP_SWAP_BX
    |=> s.x == $past(s.b) && s.b == $past(s.x))
    else $error("exchange wrong");

  a_irq_low: assert property (
    ex && op == tie_pkg::OP_X_TO_PA && slave &&
    s.ctrl[tie_pkg::C_IRTOUT] |=> !irt_out)
    else $error("irq pin not pulled low");

  a_irq_release: assert property (
    $rose(irt_out) |-> $past(en_low))
    else $error("irq pin rose without enable");

  a_slave_float: assert property (
    slave && !en_low ##1 slave |-> pa_oe_n == tie_pkg::PA_HIZ)
    else $error("slave port a driven without enable");

  a_timer_load: assert property (
    ex && op == tie_pkg::OP_X_TO_TMR |=> s.tmr == $past(s.x))
    else $error("timer load wrong");

  a_underflow: assert property (
    under && !ex |=> timer_irq && s.tmr == 8'hff ##1 !timer_irq)
    else $error("underflow event wrong");

  a_sign_ext: assert property (
    ex && op == tie_pkg::OP_X_TO_ACC
    |=> s.acc == {$past(sgn) ? {2{$past(s.x[7])}} : 2'b00, $past(s.x)})
    else $error("accumulator extension wrong");

endmodule

/* verilog/tie_pkg.sv */
package tie_pkg;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ     = 40_000_000;
  localparam int SAMPLE_HZ  = 10_000;
  localparam int SAMPLE_CYC = CLK_HZ / SAMPLE_HZ;
  localparam logic [11:0] SAMPLE_LAST = 12'(SAMPLE_CYC - 1);
  localparam int INTERP_SHIFT = 5;

  // ----------------------------------------------------------------
  // register byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] A_CTRL  = 8'h00;
  localparam logic [7:0] A_INSTR = 8'h04;
  localparam logic [7:0] A_ACC   = 8'h08;
  localparam logic [7:0] A_X     = 8'h0c;
  localparam logic [7:0] A_B     = 8'h10;
  localparam logic [7:0] A_STAT  = 8'h14;
  localparam logic [7:0] A_TMR   = 8'h18;
  localparam logic [7:0] A_PRESC = 8'h1c;
  localparam logic [7:0] A_PORTA = 8'h20;
  localparam logic [7:0] A_EXC   = 8'h24;
  localparam logic [7:0] A_PARAM = 8'h40;
  localparam logic [7:0] A_PEND  = 8'h6c;

  // ----------------------------------------------------------------
  // control and status bit positions
  // ----------------------------------------------------------------
  localparam int C_SLAVE  = 0;
  localparam int C_SIGN   = 1;
  localparam int C_IRTOUT = 2;
  localparam int C_REDUCE = 3;
  localparam int C_INTERP = 4;
  localparam int C_SYNTH  = 5;
  localparam int S_SF     = 0;
  localparam int S_SRC    = 1;
  localparam int S_TEVT   = 2;
  localparam int S_BANK   = 3;
  localparam int S_PEND   = 4;

  // ----------------------------------------------------------------
  // opcodes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_PC_TO_ACC  = 8'h06;
  localparam logic [7:0] OP_TMR_TO_ACC = 8'h2d;
  localparam logic [7:0] OP_X_TO_ACC   = 8'h01;
  localparam logic [7:0] OP_X_TO_PA    = 8'h0d;
  localparam logic [7:0] OP_X_TO_TMR   = 8'h10;
  localparam logic [7:0] OP_SWAP_BX    = 8'h0e;
  localparam logic [7:0] OP_X_GE_CONST = 8'h55;

  // ----------------------------------------------------------------
  // synthesizer parameters: 0 pitch, 1 energy, 2..11 k1..k10
  // ----------------------------------------------------------------
  localparam int N_PARAM = 12;
  localparam int N_FRAC  = 8;
  localparam logic [7:0] EXC_PULSE = 8'h7f;
  localparam logic [7:0] EXC_NOISE_HI = 8'h40;
  localparam logic [7:0] EXC_NOISE_LO = 8'hc0;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [14:0] LFSR_SEED = 15'h0001;
  localparam logic [7:0]  PA_HIZ    = 8'hff;
endpackage

/* dv/tie_host.sv */
`timescale 1ns/10ps
module tie_host (
  // clock and reset
  input  wire logic       hclk,
  input  wire logic       hresetn,
  // bench control
  input  wire logic       armed,
  input  wire logic [1:0] en_sel,
  input  wire logic [7:0] delay,
  // pin levels
  input  wire logic       irt_line,
  input  wire logic [7:0] pa_line,
  // enables and captured byte
  output logic            en1_n,
  output logic            en2_n,
  output logic [7:0]      got,
  output logic            got_stb
);
  logic [7:0] cnt;
  logic       busy;

  // waits a chosen delay after irq goes low, then holds the enables until
  // irq returns high; no own timeout, the bench watchdog covers a hang
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt <= 8'h00;
      busy <= 1'b0;
      en1_n <= 1'b1;
      en2_n <= 1'b1;
      got <= 8'h00;
      got_stb <= 1'b0;
    end else begin
      got_stb <= 1'b0;
      if (!busy) begin
        cnt <= (armed && irt_line == 1'b0) ? cnt + 8'h01 : 8'h00;
        if (armed && irt_line == 1'b0 && cnt == delay) begin
          busy <= 1'b1;
          en1_n <= !en_sel[0];
          en2_n <= !en_sel[1];
        end
      end else if (irt_line == 1'b1) begin
        got <= pa_line;
        got_stb <= 1'b1;
        busy <= 1'b0;
        cnt <= 8'h00;
        en1_n <= 1'b1;
        en2_n <= 1'b1;
      end
    end
  end
endmodule

/* dv/testbench.sv */
`timescale 1ns/10ps
module testbench;
  typedef struct {
    string       nm;
    logic [31:0] msk;
    logic [31:0] v;
  } tie_exp_t;
  localparam logic [15:0] GE_TBL [4] = '{16'h0505, 16'h0405, 16'hff00, 16'h00ff};
  localparam logic [7:0]  OPS [7] = '{8'h06, 8'h01, 8'h0d, 8'h10, 8'h0e, 8'h55, 8'h2c};
  logic        hclk;
  logic        hresetn;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] hwdata;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic [7:0]  pa_out;
  logic [7:0]  pa_oe_n;
  logic [7:0]  pa_line;
  logic [7:0]  flt;
  logic [7:0]  pc_drv;
  logic [7:0]  pc_bus;
  logic [7:0]  excite;
  logic [7:0]  got;
  logic [7:0]  dly;
  logic [1:0]  en_sel;
  logic        irt_out;
  logic        irt_oe_n;
  logic        irt_line;
  logic        irt_src;
  logic        timer_irq;
  logic        voiced;
  logic        armed;
  logic        en1_n;
  logic        en2_n;
  logic        got_stb;
  logic        rd_dp;
  int          fails;
  int          num_checks;
  tie_exp_t    exp_q[$];
  tie_exp_t    e;

  // pin levels: a released port a line shows a pattern that moves every cycle
  assign pa_line = (pa_out & ~pa_oe_n) | (flt & pa_oe_n);
  assign irt_line = irt_oe_n ? irt_src : irt_out;
  assign pc_bus = {pc_drv[7:3], pc_drv[2] & en2_n, pc_drv[1] & en1_n, pc_drv[0]};

  tie_core tie_core_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pa_in(pa_line),
    .pa_out(pa_out), .pa_oe_n(pa_oe_n), .pc_in(pc_bus), .irt_in(irt_line),
    .irt_out(irt_out), .irt_oe_n(irt_oe_n), .timer_irq(timer_irq), .excite(excite),
    .voiced(voiced));
  tie_host tie_host_i (
    .hclk(hclk), .hresetn(hresetn), .armed(armed), .en_sel(en_sel), .delay(dly),
    .irt_line(irt_line), .pa_line(pa_line), .en1_n(en1_n), .en2_n(en2_n),
    .got(got), .got_stb(got_stb));

  // clock and the floating pattern
  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end
  always @(posedge hclk) flt <= flt + 8'h01;

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] ex);
    num_checks++;
    if (seen !== ex) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, ex, seen);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // one ahb-lite single transfer; entered right after a rising edge
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    htrans <= 2'h2;
    haddr <= {24'h000000, a};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d);
  endtask
  task automatic ins(input logic [7:0] op, input logic [7:0] imm);
    wr(tie_pkg::A_INSTR, {16'h0000, imm, op});
  endtask
  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] m,
                    input logic [31:0] v);
    exp_q.push_back('{nm, m, v});
    xfer(a, 1'b0, 32'h00000000);
  endtask
  function automatic logic [31:0] ext(input logic [7:0] b, input logic s);
    return {22'h000000, s ? {2{b[7]}} : 2'b00, b};
  endfunction
  task automatic wait_irq(output int n);
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (timer_irq !== 1'b1 && n < 3000);
  endtask

  // watcher: a read data phase or a host capture takes the oldest note
  always @(posedge hclk) begin
    if ((rd_dp && hreadyout === 1'b1) || got_stb === 1'b1) begin
      if (exp_q.size() == 0) chk("note_queue", 32'h1, 32'h0);
      else begin
        e = exp_q.pop_front();
        chk(e.nm, (got_stb === 1'b1 ? {24'h0, got} : hrdata) & e.msk, e.v & e.msk);
      end
    end
    if (rd_dp && hreadyout === 1'b1) chk("hresp", {31'h0, hresp}, 32'h0);
    if (hreadyout === 1'b1) rd_dp <= htrans[1] & ~hwrite;
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [7:0] x;
    logic [7:0] b;
    logic [7:0] r;
    logic       s;
    int         n;
    hresetn = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    pc_drv = 8'hff;
    irt_src = 1'b1;
    armed = 1'b0;
    en_sel = 2'h1;
    dly = 8'h14;
    flt = 8'h5a;
    rd_dp = 1'b0;
    fails = 0;
    num_checks = 0;
    void'($urandom(61349));
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk("oe_rst", {24'h0, pa_oe_n}, 32'hff);
    chk("irt_rst", {31'h0, irt_out}, 32'h1);
    rd("ctrl_rst", tie_pkg::A_CTRL, 32'hffffffff, 32'h0);
    rd("src_rst", tie_pkg::A_STAT, 32'h2, 32'h0);
    wr(8'h30, $urandom);
    rd("unmapped", 8'h30, 32'hffffffff, 32'h0);
    $display("test reset done");
    for (int m = 0; m < 4; m++) begin
      s = m[0];
      x = 8'($urandom_range(254, 0));
      r = 8'($urandom);
      pc_drv <= r;
      wr(tie_pkg::A_CTRL, {28'h0, m[1], 1'b0, s, 1'b0});
      wr(tie_pkg::A_X, {24'h0, x});
      ins(tie_pkg::OP_X_GE_CONST, 8'hff);
      ins(tie_pkg::OP_X_TO_ACC, 8'h00);
      rd("x_to_acc", tie_pkg::A_ACC, 32'h3ff, ext(x, s));
      rd("flag_kept", tie_pkg::A_STAT, 32'h1, 32'h0);
      ins(tie_pkg::OP_PC_TO_ACC, 8'h00);
      if (m[1]) r[7:4] = 4'hf;
      rd("pc_master", tie_pkg::A_ACC, 32'h3ff, ext(r, s));
      rd("flag_pc", tie_pkg::A_STAT, 32'h1, 32'h1);
    end
    for (int m = 0; m < 3; m++) begin
      s = m[0];
      r = 8'($urandom) | 8'h06;
      pc_drv <= r;
      irt_src <= r[3];
      wr(tie_pkg::A_CTRL, {30'h0, s, 1'b1});
      ins(tie_pkg::OP_PC_TO_ACC, 8'h00);
      rd("pc_slave", tie_pkg::A_ACC, 32'h3ff, ext({r[7:4], 2'b00, r[3], r[0]}, s));
    end
    irt_src <= 1'b1;
    for (int k = 0; k < 6; k++) begin
      {x, b} = (k < 4) ? GE_TBL[k] : 16'($urandom);
      wr(tie_pkg::A_X, {24'h0, x});
      ins(tie_pkg::OP_X_GE_CONST, b);
      rd("ge_flag", tie_pkg::A_STAT, 32'h1, {31'h0, x >= b});
    end
    x = 8'($urandom_range(254, 0));
    b = 8'($urandom);
    wr(tie_pkg::A_B, {24'h0, b});
    wr(tie_pkg::A_X, {24'h0, x});
    ins(tie_pkg::OP_X_GE_CONST, 8'hff);
    ins(tie_pkg::OP_SWAP_BX, 8'h00);
    rd("swap_b", tie_pkg::A_B, 32'hff, {24'h0, x});
    rd("swap_x", tie_pkg::A_X, 32'hff, {24'h0, b});
    rd("flag_swap", tie_pkg::A_STAT, 32'h1, 32'h1);
    $display("test transfers done");
    wr(tie_pkg::A_CTRL, 32'h0);
    x = 8'($urandom);
    wr(tie_pkg::A_X, {24'h0, x});
    ins(tie_pkg::OP_X_TO_PA, 8'h00);
    @(posedge hclk);
    chk("pa_master", {24'h0, pa_out}, {24'h0, x});
    chk("oe_master", {24'h0, pa_oe_n}, 32'h0);
    rd("porta", tie_pkg::A_PORTA, 32'hffff, {16'h0, x, x});
    // slave link: the host answers slowly so the low irq can be watched
    wr(tie_pkg::A_CTRL, 32'h5);
    armed <= 1'b1;
    for (int k = 0; k < 3; k++) begin
      en_sel <= 2'(k + 1);
      dly <= 8'($urandom_range(40, 20));
      x = 8'($urandom);
      wr(tie_pkg::A_X, {24'h0, x});
      ins(tie_pkg::OP_X_TO_PA, 8'h00);
      repeat (3) @(posedge hclk);
      chk("irt_low", {31'h0, irt_out}, 32'h0);
      chk("oe_float", {24'h0, pa_oe_n}, 32'hff);
      rd("pend_set", tie_pkg::A_STAT, 32'h10, 32'h10);
      exp_q.push_back('{"host_data", 32'hff, {24'h0, x}});
      n = 0;
      while (irt_out !== 1'b1 && n < 200) begin
        @(posedge hclk);
        n++;
      end
      repeat (4) @(posedge hclk);
      chk("irt_back", {31'h0, irt_out}, 32'h1);
      chk("oe_after", {24'h0, pa_oe_n}, 32'hff);
    end
    armed <= 1'b0;
    $display("test port a done");
    wr(tie_pkg::A_CTRL, 32'h0);
    for (int k = 0; k < 2; k++) begin
      wr(tie_pkg::A_PRESC, 32'h9);
      wr(tie_pkg::A_STAT, 32'h4);
      wr(tie_pkg::A_X, 32'(3 * k));
      ins(tie_pkg::OP_X_TO_TMR, 8'h00);
      wait_irq(n);
      chk("irq_delay", {31'h0, n >= 30 * k && n <= 30 * k + 12}, 32'h1);
      rd("tevt", tie_pkg::A_STAT, 32'h4, 32'h4);
      rd("wrap", tie_pkg::A_TMR, 32'hff, 32'hff);
    end
    wr(tie_pkg::A_PRESC, 32'h2);
    repeat (300) @(posedge hclk);
    for (int k = 0; k < 7; k++) begin
      ins(OPS[k], 8'h00);
      rd("src_int", tie_pkg::A_STAT, 32'h2, 32'h0);
    end
    ins(tie_pkg::OP_TMR_TO_ACC, 8'h00);
    rd("src_pin", tie_pkg::A_STAT, 32'h2, 32'h2);
    wr(tie_pkg::A_X, 32'h85);
    ins(tie_pkg::OP_X_TO_TMR, 8'h00);
    rd("tmr_load", tie_pkg::A_TMR, 32'hff, 32'h85);
    wr(tie_pkg::A_CTRL, 32'h2);
    ins(tie_pkg::OP_TMR_TO_ACC, 8'h00);
    rd("tmr_acc", tie_pkg::A_ACC, 32'h3ff, 32'h385);
    rd("flag_tmr", tie_pkg::A_STAT, 32'h1, 32'h1);
    repeat (6) begin
      irt_src <= 1'b0;
      repeat (2) @(posedge hclk);
      irt_src <= 1'b1;
      repeat (2) @(posedge hclk);
    end
    rd("tmr_pin", tie_pkg::A_TMR, 32'hff, 32'h83);
    $display("test timer done");
    wr(tie_pkg::A_STAT, 32'h6);
    wr(tie_pkg::A_PRESC, 32'hff);
    wr(tie_pkg::A_X, 32'h0);
    ins(tie_pkg::OP_X_TO_TMR, 8'h00);
    wait_irq(n);
    wr(tie_pkg::A_CTRL, 32'h20);
    wr(tie_pkg::A_PARAM, 32'h0);
    wr(8'h44, 32'habc);
    wr(8'h64, 32'habc);
    ins(tie_pkg::OP_X_TO_TMR, 8'h00);
    wait_irq(n);
    rd("pitch_swap", tie_pkg::A_PARAM, 32'hfff, 32'h0);
    rd("energy_frac", 8'h44, 32'hfff, 32'habc);
    rd("k8_frac", 8'h64, 32'hfff, 32'hab0);
    repeat (4100) @(posedge hclk);
    chk("unvoiced", {31'h0, voiced}, 32'h0);
    chk("noise_level", {31'h0, excite == tie_pkg::EXC_NOISE_HI ||
        excite == tie_pkg::EXC_NOISE_LO}, 32'h1);
    wr(tie_pkg::A_PARAM, 32'h500);
    ins(tie_pkg::OP_X_TO_TMR, 8'h00);
    wait_irq(n);
    rd("pitch_new", tie_pkg::A_PARAM, 32'hfff, 32'h500);
    repeat (4100) @(posedge hclk);
    chk("voiced", {31'h0, voiced}, 32'h1);
    // one or two sample steps of 1/32 toward the new pitch land in 508..50f
    wr(tie_pkg::A_PARAM, 32'h600);
    wr(tie_pkg::A_CTRL, 32'h30);
    repeat (4100) @(posedge hclk);
    rd("interp", tie_pkg::A_PARAM, 32'hff8, 32'h508);
    @(posedge hclk);
    $display("test synth done");
    print_verdict();
  end

  // watchdog, sized well past the longest sequence
  initial begin
    repeat (60000) @(posedge hclk);
    fails++;
    print_verdict();
  end
endmodule
